//--- verilog/hcr_pkg.sv
// constants, field layouts and carrier types for the host controller id,
// eeprom access and retry-limit register bank
// assumes a 32-bit apb slave and a same-clock eeprom byte engine

package hcr_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int APB_AW = 12;
    localparam logic [APB_AW-1:0] OFS_VERSION = 12'h000;
    localparam logic [APB_AW-1:0] OFS_EEPROM = 12'h004;
    localparam logic [APB_AW-1:0] OFS_RETRY = 12'h008;

    // ----------------------------------------------------------------
    // field positions and constants
    // ----------------------------------------------------------------
    localparam int PRESENT_BIT = 24;
    localparam int MAJOR_LSB = 16;
    localparam int MINOR_LSB = 0;
    localparam logic [7:0] MAJOR_VERSION = 8'h01;
    localparam logic [7:0] MINOR_VERSION = 8'h10;

    localparam int ADDR_CLEAR_BIT = 31;
    localparam int READ_GO_BIT = 25;
    localparam int READ_BYTE_LSB = 16;
    localparam int POINTER_LSB = 0;
    localparam logic [7:0] POINTER_WORD_OFS = 8'h28;
    localparam logic [7:0] POINTER_VALID_MIN = 8'h39;
    localparam logic [7:0] POINTER_NONE = 8'h00;

    localparam int PHYS_RETRY_LSB = 8;
    localparam int RESP_RETRY_LSB = 4;
    localparam int REQ_RETRY_LSB = 0;
    localparam logic [3:0] RETRY_RESET = 4'h0;

    // cycles to let the presence pin settle through the synchroniser
    localparam logic [3:0] SETTLE_CYCLES = 4'h4;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef enum logic {
        EE_SET_ADDR,
        EE_READ_BYTE
    } hcr_ee_op_t;

    typedef struct packed {
        hcr_ee_op_t op;
        logic [7:0] addr;
    } hcr_ee_cmd_t;

    typedef struct packed {
        logic [3:0] phys;
        logic [3:0] resp;
        logic [3:0] req;
    } hcr_retry_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } hcr_bib_byte_t;

    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_VERSION,
        SEL_EEPROM,
        SEL_RETRY
    } hcr_sel_t;

endpackage

//--- verilog/hcr_regs.sv
// version, eeprom byte access and async retry limit registers behind apb
// assumes an eeprom byte engine on clk_i: it takes a held request and
// answers with a one-cycle done pulse, advancing its address after a read

`timescale 1ns/100ps

module hcr_regs #(
    parameter logic [7:0] LOAD_LAST_ADDR = hcr_pkg::POINTER_WORD_OFS
) (
    // clock and resets
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic function_reset_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [hcr_pkg::APB_AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // eeprom byte engine
    input wire logic eeprom_present_i,
    output logic ee_req_o,
    output hcr_pkg::hcr_ee_cmd_t ee_cmd_o,
    input wire logic ee_done_i,
    input wire logic [7:0] ee_data_i,
    // bus information block load
    output logic bib_wr_o,
    output hcr_pkg::hcr_bib_byte_t bib_byte_o,
    // block status
    output hcr_pkg::hcr_retry_t retry_limits_o,
    output logic [7:0] small_rom_pointer_o,
    output logic small_rom_valid_o,
    output logic load_busy_o
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic hcr_pkg::hcr_sel_t reg_sel(input logic [hcr_pkg::APB_AW-1:0] addr);
        hcr_pkg::hcr_sel_t sel;
        sel = hcr_pkg::SEL_NONE;
        case (addr)
            hcr_pkg::OFS_VERSION: sel = hcr_pkg::SEL_VERSION;
            hcr_pkg::OFS_EEPROM: sel = hcr_pkg::SEL_EEPROM;
            hcr_pkg::OFS_RETRY: sel = hcr_pkg::SEL_RETRY;
            default: sel = hcr_pkg::SEL_NONE;
        endcase
        return sel;
    endfunction

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_SETTLE,
        ST_LD_ADDR,
        ST_LD_READ,
        ST_IDLE,
        ST_CLR,
        ST_RD
    } hcr_state_t;

    // states that hold a request towards the eeprom engine
    function automatic logic is_request(input hcr_state_t st);
        return (st == ST_LD_ADDR) || (st == ST_LD_READ) || (st == ST_CLR) || (st == ST_RD);
    endfunction

    hcr_state_t state_ff;
    hcr_state_t nxt_state;
    logic pres_s1_ff;
    logic pres_s2_ff;
    logic [3:0] settle_ff;
    logic present_flag_ff;
    logic addr_clear_ff;
    logic read_go_ff;
    logic [7:0] read_byte_ff;
    logic [7:0] pointer_ff;
    logic pointer_valid_ff;
    logic [7:0] load_idx_ff;
    hcr_pkg::hcr_retry_t retry_ff;
    logic ee_req_ff;
    logic nxt_req;
    hcr_pkg::hcr_ee_cmd_t ee_cmd_ff;
    hcr_pkg::hcr_ee_cmd_t nxt_cmd;
    logic bib_wr_ff;
    hcr_pkg::hcr_bib_byte_t bib_byte_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] nxt_rdata;
    hcr_pkg::hcr_sel_t sel;
    logic acc_first;
    logic acc_done;
    logic wr_eeprom;
    logic wr_retry;
    logic clear_done;
    logic read_done;
    logic load_read_done;
    logic load_busy_ff;

    assign sel = reg_sel(paddr_i);
    assign acc_first = psel_i & penable_i & ~pready_ff;
    assign acc_done = psel_i & penable_i & pready_ff;
    assign wr_eeprom = acc_done & pwrite_i & (sel == hcr_pkg::SEL_EEPROM);
    assign wr_retry = acc_done & pwrite_i & (sel == hcr_pkg::SEL_RETRY);
    assign clear_done = (state_ff == ST_CLR) & ee_req_ff & ee_done_i;
    assign read_done = (state_ff == ST_RD) & ee_req_ff & ee_done_i;
    assign load_read_done = (state_ff == ST_LD_READ) & ee_req_ff & ee_done_i;

    // ----------------------------------------------------------------
    // presence pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pres_s1_ff <= 1'b0;
            pres_s2_ff <= 1'b0;
        end else begin
            pres_s1_ff <= eeprom_present_i;
            pres_s2_ff <= pres_s1_ff;
        end
    end

    // ----------------------------------------------------------------
    // sequencer: detect, load, then serve software requests
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_SETTLE: begin
                if (settle_ff == hcr_pkg::SETTLE_CYCLES - 4'h1) begin
                    nxt_state = pres_s2_ff ? ST_LD_ADDR : ST_IDLE;
                end
            end
            ST_LD_ADDR: begin
                if (ee_req_ff && ee_done_i) begin
                    nxt_state = ST_LD_READ;
                end
            end
            ST_LD_READ: begin
                if (load_read_done && load_idx_ff == LOAD_LAST_ADDR) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (addr_clear_ff) begin
                    nxt_state = ST_CLR;
                end else if (read_go_ff) begin
                    nxt_state = ST_RD;
                end
            end
            ST_CLR: begin
                if (clear_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_RD: begin
                if (read_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_SETTLE;
        endcase
    end

    // request drops for at least one cycle after every done
    always_comb begin
        nxt_req = is_request(nxt_state) & ~ee_done_i;
        nxt_cmd.op = hcr_pkg::EE_READ_BYTE;
        nxt_cmd.addr = 8'h00;
        if (nxt_state == ST_LD_ADDR || nxt_state == ST_CLR) begin
            nxt_cmd.op = hcr_pkg::EE_SET_ADDR;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff <= ST_SETTLE;
        end else if (function_reset_i) begin
            state_ff <= ST_SETTLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // busy whenever the sequencer is not headed for idle: after either reset and during each clear or read
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            load_busy_ff <= 1'b1;
        end else if (function_reset_i) begin
            load_busy_ff <= 1'b1;
        end else begin
            load_busy_ff <= (nxt_state != ST_IDLE);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            settle_ff <= 4'h0;
        end else if (function_reset_i) begin
            settle_ff <= 4'h0;
        end else if (state_ff == ST_SETTLE) begin
            settle_ff <= settle_ff + 4'h1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ee_req_ff <= 1'b0;
            ee_cmd_ff <= '0;
        end else if (function_reset_i) begin
            ee_req_ff <= 1'b0;
            ee_cmd_ff <= '0;
        end else begin
            ee_req_ff <= nxt_req;
            ee_cmd_ff <= nxt_cmd;
        end
    end

    // ----------------------------------------------------------------
    // presence flag
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            present_flag_ff <= 1'b0;
        end else if (function_reset_i) begin
            present_flag_ff <= 1'b0;
        end else if (state_ff == ST_SETTLE && nxt_state != ST_SETTLE) begin
            present_flag_ff <= pres_s2_ff;
        end
    end

    // ----------------------------------------------------------------
    // bus information block load and small rom pointer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            load_idx_ff <= 8'h00;
        end else if (function_reset_i || state_ff == ST_LD_ADDR) begin
            load_idx_ff <= 8'h00;
        end else if (load_read_done) begin
            load_idx_ff <= load_idx_ff + 8'h01;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bib_wr_ff <= 1'b0;
            bib_byte_ff <= '0;
        end else begin
            bib_wr_ff <= load_read_done & ~function_reset_i;
            if (load_read_done) begin
                bib_byte_ff.addr <= load_idx_ff;
                bib_byte_ff.data <= ee_data_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pointer_ff <= hcr_pkg::POINTER_NONE;
            pointer_valid_ff <= 1'b0;
        end else if (function_reset_i) begin
            pointer_ff <= hcr_pkg::POINTER_NONE;
            pointer_valid_ff <= 1'b0;
        end else if (load_read_done && load_idx_ff == hcr_pkg::POINTER_WORD_OFS) begin
            pointer_ff <= ee_data_i;
            pointer_valid_ff <= ee_data_i > hcr_pkg::POINTER_VALID_MIN;
        end
    end

    // ----------------------------------------------------------------
    // eeprom access control bits and read byte
    // ----------------------------------------------------------------
    // a software set in the completing cycle wins over the hardware clear
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            addr_clear_ff <= 1'b0;
            read_go_ff <= 1'b0;
        end else if (function_reset_i) begin
            addr_clear_ff <= 1'b0;
            read_go_ff <= 1'b0;
        end else begin
            addr_clear_ff <= (addr_clear_ff & ~clear_done)
                | (wr_eeprom & pwdata_i[hcr_pkg::ADDR_CLEAR_BIT]);
            read_go_ff <= (read_go_ff & ~read_done)
                | (wr_eeprom & pwdata_i[hcr_pkg::READ_GO_BIT]);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            read_byte_ff <= 8'h00;
        end else if (read_done) begin
            read_byte_ff <= ee_data_i;
        end
    end

    // ----------------------------------------------------------------
    // retry limits
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            retry_ff.phys <= hcr_pkg::RETRY_RESET;
            retry_ff.resp <= hcr_pkg::RETRY_RESET;
            retry_ff.req <= hcr_pkg::RETRY_RESET;
        end else if (function_reset_i) begin
            retry_ff <= '0;
        end else if (wr_retry) begin
            retry_ff.phys <= pwdata_i[hcr_pkg::PHYS_RETRY_LSB +: 4];
            retry_ff.resp <= pwdata_i[hcr_pkg::RESP_RETRY_LSB +: 4];
            retry_ff.req <= pwdata_i[hcr_pkg::REQ_RETRY_LSB +: 4];
        end
    end

    // ----------------------------------------------------------------
    // apb read path, one wait state
    // ----------------------------------------------------------------
    // unlisted bits stay zero and writes to them are dropped
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (sel)
            hcr_pkg::SEL_VERSION: begin
                nxt_rdata[hcr_pkg::PRESENT_BIT] = present_flag_ff;
                nxt_rdata[hcr_pkg::MAJOR_LSB +: 8] = hcr_pkg::MAJOR_VERSION;
                nxt_rdata[hcr_pkg::MINOR_LSB +: 8] = hcr_pkg::MINOR_VERSION;
            end
            hcr_pkg::SEL_EEPROM: begin
                nxt_rdata[hcr_pkg::ADDR_CLEAR_BIT] = addr_clear_ff;
                nxt_rdata[hcr_pkg::READ_GO_BIT] = read_go_ff;
                nxt_rdata[hcr_pkg::READ_BYTE_LSB +: 8] = read_byte_ff;
                nxt_rdata[hcr_pkg::POINTER_LSB +: 8] = pointer_ff;
            end
            hcr_pkg::SEL_RETRY: begin
                nxt_rdata[hcr_pkg::PHYS_RETRY_LSB +: 4] = retry_ff.phys;
                nxt_rdata[hcr_pkg::RESP_RETRY_LSB +: 4] = retry_ff.resp;
                nxt_rdata[hcr_pkg::REQ_RETRY_LSB +: 4] = retry_ff.req;
            end
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= acc_first;
            pslverr_ff <= acc_first & (sel == hcr_pkg::SEL_NONE);
            if (acc_first && !pwrite_i) begin
                prdata_ff <= nxt_rdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign ee_req_o = ee_req_ff;
    assign ee_cmd_o = ee_cmd_ff;
    assign bib_wr_o = bib_wr_ff;
    assign bib_byte_o = bib_byte_ff;
    assign retry_limits_o = retry_ff;
    assign small_rom_pointer_o = pointer_ff;
    assign small_rom_valid_o = pointer_valid_ff;
    assign load_busy_o = load_busy_ff;

endmodule

//--- dv/hcr_eeprom_model.sv
// behavioural serial eeprom byte engine on the far side of the register bank
// assumes requests held until done; alternates prompt and slow answers

`timescale 1ns/100ps

module hcr_eeprom_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // byte engine
    input wire logic ee_req_i,
    input wire hcr_pkg::hcr_ee_cmd_t ee_cmd_i,
    output logic ee_done_o,
    output logic [7:0] ee_data_o
);
    logic [7:0] addr_ff;
    logic [7:0] byte_ff;
    logic [1:0] cnt_ff;
    logic slow_ff;

    // fixed content, pointer byte at word 28h
    function automatic logic [7:0] mem(input logic [7:0] a);
        return (a == 8'h28) ? 8'h4c : a + 8'h80;
    endfunction

    // data line shows junk outside the done pulse
    assign ee_data_o = ee_done_o ? byte_ff : ~byte_ff;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            addr_ff <= 8'h00;
            byte_ff <= 8'h00;
            cnt_ff <= 2'h0;
            slow_ff <= 1'b0;
            ee_done_o <= 1'b0;
        end else if (ee_done_o) begin
            ee_done_o <= 1'b0;
            cnt_ff <= 2'h0;
            slow_ff <= ~slow_ff;
        end else if (!ee_req_i) begin
            cnt_ff <= 2'h0;
        end else if (cnt_ff == (slow_ff ? 2'h3 : 2'h0)) begin
            ee_done_o <= 1'b1;
            if (ee_cmd_i.op == hcr_pkg::EE_SET_ADDR) begin
                addr_ff <= ee_cmd_i.addr;
            end else begin
                byte_ff <= mem(addr_ff);
                addr_ff <= addr_ff + 8'h01;
            end
        end else begin
            cnt_ff <= cnt_ff + 2'h1;
        end
    end
endmodule

//--- dv/hcr_regs_sva.sv
// concurrent checks on the register bank ports
// assumes apb read data valid with pready and a same-clock eeprom engine

`timescale 1ns/100ps

module hcr_regs_sva (
    // clock and resets
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic function_reset_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [hcr_pkg::APB_AW-1:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // eeprom engine and status
    input wire logic ee_req_o,
    input wire hcr_pkg::hcr_ee_cmd_t ee_cmd_o,
    input wire logic ee_done_i,
    input wire logic [7:0] ee_data_i,
    input wire logic bib_wr_o,
    input wire hcr_pkg::hcr_bib_byte_t bib_byte_o,
    input wire hcr_pkg::hcr_retry_t retry_limits_o,
    input wire logic [7:0] small_rom_pointer_o,
    input wire logic small_rom_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    logic rd_ok;
    logic mapped;
    assign rd_ok = psel_i && penable_i && !pwrite_i && pready_o && !pslverr_o;
    assign mapped = paddr_i == hcr_pkg::OFS_VERSION || paddr_i == hcr_pkg::OFS_EEPROM || paddr_i == hcr_pkg::OFS_RETRY;

    property p_ver_top;
        rd_ok && paddr_i == hcr_pkg::OFS_VERSION |-> prdata_o[31:25] == 7'h00;
    endproperty
    a_ver_top: assert property (p_ver_top) else $error("version top bits not zero");
    property p_ver_const;
        rd_ok && paddr_i == hcr_pkg::OFS_VERSION |-> prdata_o[23:16] == 8'h01 && prdata_o[7:0] == 8'h10;
    endproperty
    a_ver_const: assert property (p_ver_const) else $error("version constants wrong");
    property p_mid_zero;
        rd_ok && paddr_i != hcr_pkg::OFS_RETRY |-> prdata_o[15:8] == 8'h00;
    endproperty
    a_mid_zero: assert property (p_mid_zero) else $error("middle byte not zero");
    property p_ee_rsvd;
        rd_ok && paddr_i == hcr_pkg::OFS_EEPROM |-> prdata_o[30:26] == 5'h00 && !prdata_o[24];
    endproperty
    a_ee_rsvd: assert property (p_ee_rsvd) else $error("eeprom reserved bits set");
    property p_ptr_read;
        rd_ok && paddr_i == hcr_pkg::OFS_EEPROM |-> prdata_o[7:0] == $past(small_rom_pointer_o);
    endproperty
    a_ptr_read: assert property (p_ptr_read) else $error("pointer field differs");
    property p_retry_rd;
        rd_ok && paddr_i == hcr_pkg::OFS_RETRY |-> prdata_o == {20'h00000, retry_limits_o};
    endproperty
    a_retry_rd: assert property (p_retry_rd) else $error("retry read wrong");
    property p_ptr_valid;
        $stable(small_rom_pointer_o) |-> small_rom_valid_o == (small_rom_pointer_o > 8'h39);
    endproperty
    a_ptr_valid: assert property (p_ptr_valid) else $error("pointer valid flag wrong");
    property p_req_hold;
        disable iff (!resetn_i || function_reset_i)
        ee_req_o && !ee_done_i |=> ee_req_o && $stable(ee_cmd_o);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("eeprom request dropped early");
    property p_req_release;
        disable iff (!resetn_i || function_reset_i)
        ee_req_o && ee_done_i |=> !ee_req_o;
    endproperty
    a_req_release: assert property (p_req_release) else $error("eeprom request not released");
    property p_bib;
        bib_wr_o |-> $past(ee_done_i) && bib_byte_o.data == $past(ee_data_i);
    endproperty
    a_bib: assert property (p_bib) else $error("loaded byte wrong");
    property p_unmapped;
        psel_i && penable_i && pready_o && !mapped |-> pslverr_o && (pwrite_i || prdata_o == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
endmodule

bind hcr_regs hcr_regs_sva u_sva (.clk_i, .resetn_i, .function_reset_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .prdata_o, .pready_o, .pslverr_o, .ee_req_o, .ee_cmd_o, .ee_done_i, .ee_data_i, .bib_wr_o,
    .bib_byte_o, .retry_limits_o, .small_rom_pointer_o, .small_rom_valid_o);

//--- dv/hcr_regs_test.sv
// self-checking bench for the id, eeprom access and retry register bank
// assumes the eeprom model content and a 100 ns clock

`timescale 1ns/100ps

module hcr_regs_test;
    localparam logic [7:0] LAST = 8'h28;
    logic clk_i, resetn_i, function_reset_i, psel_i, penable_i, pwrite_i, eeprom_present_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic pready_o, pslverr_o, ee_req_o, ee_done_i, bib_wr_o, small_rom_valid_o, load_busy_o, err;
    logic [7:0] ee_data_i, small_rom_pointer_o;
    hcr_pkg::hcr_ee_cmd_t ee_cmd_o;
    hcr_pkg::hcr_bib_byte_t bib_byte_o;
    hcr_pkg::hcr_retry_t retry_limits_o;
    int num_errors, checks, bib_count, i;

    hcr_regs #(.LOAD_LAST_ADDR(LAST)) dut (.clk_i, .resetn_i, .function_reset_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .eeprom_present_i, .ee_req_o,
        .ee_cmd_o, .ee_done_i, .ee_data_i, .bib_wr_o, .bib_byte_o, .retry_limits_o, .small_rom_pointer_o,
        .small_rom_valid_o, .load_busy_o);
    hcr_eeprom_model u_ee (.clk_i, .resetn_i, .ee_req_i(ee_req_o), .ee_cmd_i(ee_cmd_o), .ee_done_o(ee_done_i),
        .ee_data_o(ee_data_i));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] ee_byte(input logic [7:0] a);
        return (a == 8'h28) ? 8'h4c : a + 8'h80;
    endfunction

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task print_verdict;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        for (n = 0; n < 20 && pready_o !== 1'b1; n++) @(posedge clk_i);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            print_verdict();
        end
    endtask

    task rd_chk(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd & mask, exp);
    endtask

    task wait_idle;
        int n;
        repeat (2) @(posedge clk_i);
        for (n = 0; n < 600 && load_busy_o !== 1'b0; n++) @(posedge clk_i);
        if (n >= 600) begin
            num_errors++;
            print_verdict();
        end
    endtask

    // software polls only with the presence flag set
    task wait_clear(input int b);
        int k;
        for (k = 0; k < 30; k++) begin
            apb(1'b0, hcr_pkg::OFS_EEPROM, 32'h0);
            if (rd[b] === 1'b0) break;
        end
        if (k >= 30) begin
            num_errors++;
            print_verdict();
        end
    endtask

    task do_reset;
        resetn_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'b1;
        wait_idle();
    endtask

    always @(posedge clk_i) begin
        if (bib_wr_o === 1'b1) begin
            bib_count++;
            check({24'h0, bib_byte_o.data}, {24'h0, ee_byte(bib_byte_o.addr)});
        end
    end

    // ------------------------------------------------------------
    // clock, watchdog and sequence
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    initial begin
        #4000000;
        num_errors++;
        print_verdict();
    end

    initial begin
        {resetn_i, function_reset_i, psel_i, penable_i, pwrite_i} = 5'h00;
        paddr_i = 12'h000;
        pwdata_i = 32'h0;
        eeprom_present_i = 1'b1;
        do_reset();
        rd_chk(hcr_pkg::OFS_VERSION, 32'hffffffff, 32'h01010010);
        rd_chk(hcr_pkg::OFS_EEPROM, 32'hff00ffff, 32'h0000004c);
        check({31'h0, small_rom_valid_o}, 32'h1);
        rd_chk(hcr_pkg::OFS_RETRY, 32'hffffffff, 32'h0);
        apb(1'b1, hcr_pkg::OFS_VERSION, 32'hfeffffff);
        rd_chk(hcr_pkg::OFS_VERSION, 32'hffffffff, 32'h01010010);
        apb(1'b1, hcr_pkg::OFS_RETRY, 32'hffffffff);
        rd_chk(hcr_pkg::OFS_RETRY, 32'hffffffff, 32'h00000fff);
        check({20'h0, retry_limits_o}, 32'h00000fff);
        apb(1'b1, hcr_pkg::OFS_RETRY, 32'h00000a53);
        rd_chk(hcr_pkg::OFS_RETRY, 32'hffffffff, 32'h00000a53);
        apb(1'b1, 12'h00c, 32'hffffffff);
        rd_chk(12'h00c, 32'hffffffff, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, hcr_pkg::OFS_EEPROM, 32'h80000000);
        wait_clear(31);
        for (i = 0; i < 2; i++) begin
            apb(1'b1, hcr_pkg::OFS_EEPROM, 32'h02000000);
            wait_clear(25);
            check(rd & 32'h00ff0000, {8'h0, ee_byte(i[7:0]), 16'h0});
        end
        apb(1'b1, hcr_pkg::OFS_EEPROM, 32'h80000000);
        wait_clear(31);
        check(rd & 32'h00ff0000, {8'h0, ee_byte(8'h01), 16'h0});
        apb(1'b1, hcr_pkg::OFS_EEPROM, 32'h82000000);
        apb(1'b1, hcr_pkg::OFS_EEPROM, 32'h00ff00ff);
        wait_clear(25);
        check(rd & 32'h00ff00ff, {8'h0, ee_byte(8'h00), 16'h004c});
        eeprom_present_i <= 1'b0;
        @(posedge clk_i);
        function_reset_i <= 1'b1;
        @(posedge clk_i);
        function_reset_i <= 1'b0;
        wait_idle();
        rd_chk(hcr_pkg::OFS_VERSION, 32'hffffffff, 32'h00010010);
        rd_chk(hcr_pkg::OFS_EEPROM, 32'hff00ffff, 32'h0);
        check({31'h0, small_rom_valid_o}, 32'h0);
        rd_chk(hcr_pkg::OFS_RETRY, 32'hffffffff, 32'h0);
        eeprom_present_i <= 1'b1;
        do_reset();
        @(posedge clk_i);
        rd_chk(hcr_pkg::OFS_VERSION, 32'hffffffff, 32'h01010010);
        check(bib_count, 2 * (LAST + 1));
        print_verdict();
    end
endmodule
